// File: rtl/serial_isp_pkg.sv
package serial_isp_pkg;

    // Core clock and the self-timed wait figures, in microseconds.
    localparam int CLK_HZ          = 25_000_000;
    localparam int CLK_MHZ         = CLK_HZ / 1_000_000;
    localparam int FLASH_WAIT_US   = 4500;
    localparam int DATA_WAIT_US    = 9000;
    localparam int ERASE_WAIT_US   = 9000;
    // Self-timed intervals in core clock cycles; the product is exact at 25 MHz, no rounding.
    localparam int FLASH_WAIT_CYC  = FLASH_WAIT_US * CLK_MHZ;
    localparam int DATA_WAIT_CYC   = DATA_WAIT_US * CLK_MHZ;
    localparam int ERASE_WAIT_CYC  = ERASE_WAIT_US * CLK_MHZ;
    localparam int TIMER_W         = 18;

    // Array geometry.
    localparam int FLASH_AW        = 14;
    localparam int FLASH_DEPTH     = 16384;
    localparam int EEPROM_AW       = 10;
    localparam int EEPROM_DEPTH    = 1024;
    localparam int PAGE_AW         = 7;
    localparam int PAGE_WORDS      = 128;
    localparam int PAGE_SEL_W      = FLASH_AW - PAGE_AW;
    localparam logic [FLASH_AW-1:0] FLASH_LAST = 14'h3FFF;
    localparam logic [PAGE_AW-1:0]  PAGE_LAST  = 7'h7F;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // Instruction first bytes and fixed second bytes.
    localparam logic [7:0] OP_ENABLE       = 8'hAC;
    localparam logic [7:0] ENABLE_KEY      = 8'h53;
    localparam logic [7:0] ERASE_SEL_MASK  = 8'hE0;
    localparam logic [7:0] ERASE_SEL       = 8'h80;
    localparam logic [7:0] OP_LOAD_EXT     = 8'h4D;
    localparam logic [7:0] LOAD_EXT_KEY    = 8'h00;
    localparam logic [7:0] OP_PAGE_LO      = 8'h40;
    localparam logic [7:0] OP_PAGE_HI      = 8'h48;
    localparam logic [7:0] OP_WRITE_PAGE   = 8'h4C;
    localparam logic [7:0] OP_READ_LO      = 8'h20;
    localparam logic [7:0] OP_READ_HI      = 8'h28;
    localparam logic [7:0] OP_EE_READ      = 8'hA0;
    localparam logic [7:0] OP_EE_WRITE     = 8'hC0;
    localparam logic [7:0] OP_POLL         = 8'hF0;

    // Framing: 32 rising edges per instruction, byte index in the top bits.
    localparam logic [4:0] BIT_CNT_LAST    = 5'h1F;
    localparam logic [2:0] BYTE_BIT_LAST   = 3'h7;
    localparam logic [1:0] BYTE_IDX_2      = 2'h1;
    localparam logic [1:0] BYTE_IDX_3      = 2'h2;

    // Pin synchroniser lanes and their reset levels.
    localparam int PIN_SCLK = 0;
    localparam int PIN_DIN  = 1;
    localparam int PIN_RST  = 2;
    localparam logic [2:0] PIN_RST_VAL = 3'h4;

    typedef enum logic [3:0] {
        OP_IDLE   = 4'b0001,
        OP_ERASE  = 4'b0010,
        OP_COMMIT = 4'b0100,
        OP_WAIT   = 4'b1000
    } op_state_type;

endpackage

// File: rtl/serial_isp_programming_port.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Program and erase instructions are refused until programming enable is accepted.
// - The link is serial clock in, serial data in and serial data out.
// - Data memory byte writes overwrite the location, erase built in.
// - Chip erase fills program and data arrays with all ones.
// - Incoming data is sampled on the serial clock rising edge.
// - Outgoing data changes on the serial clock falling edge.
// - The second enable byte echoes back during the third byte.
// - Page buffer is loaded byte by byte with seven word address bits.
// - Write page takes address bits 13 to 7 to pick the page.
// - Extended address byte is held until loaded again.
// - Data memory is written one byte per instruction, then waits its delay.
// - Reads return the addressed content; program reads use the extended byte.
// - Reset pin high ends the session.
// - Enable is first byte 0xAC, second byte 0x53, rest ignored.
// - Busy poll returns one in the last bit while an operation runs.
// - Load extended address is 0x4D, 0x00, then the address byte.
module serial_isp_programming_port
    import serial_isp_pkg::*;
#(
    parameter int FLASH_WAIT_CYCLES = FLASH_WAIT_CYC,
    parameter int DATA_WAIT_CYCLES  = DATA_WAIT_CYC,
    parameter int ERASE_WAIT_CYCLES = ERASE_WAIT_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic prog_reset_b,
    input  wire logic serial_clk,
    input  wire logic serial_prog_data_in,
    output logic      serial_prog_data_out,
    output logic      programming_enabled,
    output logic      operation_pending_flag
);

    logic                  rst_meta_b_q;
    logic                  rst_sync_b_q;
    logic [2:0]            pin_s1_q;
    logic [2:0]            pin_s2_q;
    logic [2:0]            pin_s3_q;
    logic [2:0]            pin_lvl_q;
    logic                  sclk_prev_q;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  session_open;
    logic [30:0]           shift_q;
    logic [4:0]            bit_cnt_q;
    logic [31:0]           insn_word;
    logic                  byte_done;
    logic                  insn_done;
    logic [7:0]            out_sr_q;
    logic                  out_q;
    logic [7:0]            resp_byte;
    logic                  enabled_q;
    logic                  pending_q;
    logic [7:0]            ext_addr_q;
    op_state_type          op_state_q;
    logic                  op_busy;
    logic                  go;
    logic                  erase_go;
    logic                  ext_go;
    logic                  page_load_go;
    logic                  commit_go;
    logic                  ee_write_go;
    logic [FLASH_AW-1:0]   sweep_cnt_q;
    logic [TIMER_W-1:0]    timer_q;
    logic [PAGE_SEL_W-1:0] commit_page_q;
    logic                  commit_ok_q;
    logic [EEPROM_AW-1:0]  ee_addr;
    logic [7:0]            ee_data;
    logic [23:0]           rd_addr;
    logic [15:0]           rd_word;
    logic [15:0]           flash_mem [FLASH_DEPTH];
    logic [7:0]            eeprom_mem [EEPROM_DEPTH];
    logic [7:0]            page_lo [PAGE_WORDS];
    logic [7:0]            page_hi [PAGE_WORDS];
    //////////////////////////////////////////////////////////////////////////
    // Reset release through two flops so no flop sees a ragged deassertion.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b_q <= 1'b0;
            rst_sync_b_q <= 1'b0;
        end else begin
            rst_meta_b_q <= 1'b1;
            rst_sync_b_q <= rst_meta_b_q;
        end
    end

    // Three-flop pin synchroniser; a level counts once stages two and three agree.
    always_ff @(posedge ref_clk or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            pin_s1_q    <= PIN_RST_VAL;
            pin_s2_q    <= PIN_RST_VAL;
            pin_s3_q    <= PIN_RST_VAL;
            pin_lvl_q   <= PIN_RST_VAL;
            sclk_prev_q <= 1'b0;
        end else begin
            pin_s1_q    <= {prog_reset_b, serial_prog_data_in, serial_clk};
            pin_s2_q    <= pin_s1_q;
            pin_s3_q    <= pin_s2_q;
            pin_lvl_q   <= (~(pin_s2_q ^ pin_s3_q) & pin_s3_q)
                         | ((pin_s2_q ^ pin_s3_q) & pin_lvl_q);
            sclk_prev_q <= pin_lvl_q[PIN_SCLK];
        end
    end

    // Edge finding; the clock phase limits give at least two samples per phase.
    assign sclk_rise    = pin_lvl_q[PIN_SCLK] & ~sclk_prev_q;
    assign sclk_fall    = ~pin_lvl_q[PIN_SCLK] & sclk_prev_q;
    assign session_open = ~pin_lvl_q[PIN_RST];
    assign insn_word    = {shift_q, pin_lvl_q[PIN_DIN]};
    assign byte_done    = session_open & sclk_rise & (bit_cnt_q[2:0] == BYTE_BIT_LAST);
    assign insn_done    = session_open & sclk_rise & (bit_cnt_q == BIT_CNT_LAST);

    //////////////////////////////////////////////////////////////////////////
    // Input framing, MSB first; a reset pulse restarts the frame count at bit zero.
    always_ff @(posedge ref_clk or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            shift_q   <= '0;
            bit_cnt_q <= '0;
        end else if (!session_open) begin
            shift_q   <= '0;
            bit_cnt_q <= '0;
        end else if (sclk_rise) begin
            shift_q   <= insn_word[30:0];
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // Answer byte for the next slot: reads and poll after byte three, else echo.
    always_comb begin
        rd_addr   = {ext_addr_q, insn_word[15:0]};
        rd_word   = ERASED_WORD;
        if (rd_addr[23:FLASH_AW] == '0) begin
            rd_word = flash_mem[rd_addr[FLASH_AW-1:0]];
        end
        resp_byte = insn_word[7:0];
        if (bit_cnt_q[4:3] == BYTE_IDX_3 && enabled_q) begin
            case (insn_word[23:16])
                OP_READ_LO: resp_byte = rd_word[7:0];
                OP_READ_HI: resp_byte = rd_word[15:8];
                OP_EE_READ: resp_byte = eeprom_mem[insn_word[EEPROM_AW-1:0]];
                OP_POLL:    resp_byte = {7'h00, op_busy};
                default:    resp_byte = insn_word[7:0];
            endcase
        end
    end

    // Output shifter loads at a byte boundary and moves on falling edges.
    always_ff @(posedge ref_clk or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            out_sr_q <= '0;
            out_q    <= 1'b0;
        end else if (!session_open) begin
            out_sr_q <= '0;
            out_q    <= 1'b0;
        end else if (byte_done) begin
            out_sr_q <= resp_byte;
        end else if (sclk_fall) begin
            out_q    <= out_sr_q[7];
            out_sr_q <= {out_sr_q[6:0], 1'b0};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Session state: enable key accepted, cleared whenever the reset pin rises.
    always_ff @(posedge ref_clk or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            enabled_q <= 1'b0;
        end else if (!session_open) begin
            enabled_q <= 1'b0;
        end else if (insn_done && insn_word[31:24] == OP_ENABLE
                     && insn_word[23:16] == ENABLE_KEY) begin
            enabled_q <= 1'b1;
        end
    end

    // Commands run only when enabled and idle, so a busy array is never disturbed.
    assign op_busy      = (op_state_q != OP_IDLE);
    assign go           = insn_done & enabled_q & ~op_busy;
    assign erase_go     = go & (insn_word[31:24] == OP_ENABLE)
                        & ((insn_word[23:16] & ERASE_SEL_MASK) == ERASE_SEL);
    assign ext_go       = go & (insn_word[31:24] == OP_LOAD_EXT)
                        & (insn_word[23:16] == LOAD_EXT_KEY);
    assign page_load_go = go & ((insn_word[31:24] == OP_PAGE_LO)
                        | (insn_word[31:24] == OP_PAGE_HI));
    assign commit_go    = go & (insn_word[31:24] == OP_WRITE_PAGE);
    assign ee_write_go  = go & (insn_word[31:24] == OP_EE_WRITE);
    assign ee_addr      = {insn_word[17:16], insn_word[15:8]};
    assign ee_data      = insn_word[7:0];

    // Extended address byte survives sessions; only the load instruction moves it.
    always_ff @(posedge ref_clk or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            ext_addr_q <= '0;
        end else if (ext_go) begin
            ext_addr_q <= insn_word[15:8];
        end
    end

    // Page buffer; bytes of a word are stored apart so load order is free here.
    always_ff @(posedge ref_clk) begin
        if (page_load_go) begin
            if (insn_word[31:24] == OP_PAGE_HI) begin
                page_hi[insn_word[8+PAGE_AW-1:8]] <= insn_word[7:0];
            end else begin
                page_lo[insn_word[8+PAGE_AW-1:8]] <= insn_word[7:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Self-timed operation sequencer with its wait timer.
    always_ff @(posedge ref_clk or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            op_state_q    <= OP_IDLE;
            sweep_cnt_q   <= '0;
            timer_q       <= '0;
            commit_page_q <= '0;
            commit_ok_q   <= 1'b0;
        end else begin
            if (timer_q != '0) begin
                timer_q <= timer_q - {{(TIMER_W-1){1'b0}}, 1'b1};
            end
            case (op_state_q)
                OP_IDLE: begin
                    sweep_cnt_q <= '0;
                    if (erase_go) begin
                        op_state_q <= OP_ERASE;
                        timer_q    <= TIMER_W'(ERASE_WAIT_CYCLES);
                    end else if (commit_go) begin
                        op_state_q    <= OP_COMMIT;
                        timer_q       <= TIMER_W'(FLASH_WAIT_CYCLES);
                        commit_page_q <= {insn_word[21:16], insn_word[15]};
                        commit_ok_q   <= (ext_addr_q == '0) && (insn_word[23:22] == '0);
                    end else if (ee_write_go) begin
                        op_state_q <= OP_WAIT;
                        timer_q    <= TIMER_W'(DATA_WAIT_CYCLES);
                    end
                end
                OP_ERASE: begin
                    sweep_cnt_q <= sweep_cnt_q + {{(FLASH_AW-1){1'b0}}, 1'b1};
                    if (sweep_cnt_q == FLASH_LAST) begin
                        op_state_q <= OP_WAIT;
                    end
                end
                OP_COMMIT: begin
                    sweep_cnt_q <= sweep_cnt_q + {{(FLASH_AW-1){1'b0}}, 1'b1};
                    if (sweep_cnt_q[PAGE_AW-1:0] == PAGE_LAST) begin
                        op_state_q <= OP_WAIT;
                    end
                end
                OP_WAIT: begin
                    if (timer_q == '0) begin
                        op_state_q <= OP_IDLE;
                    end
                end
                default: op_state_q <= OP_IDLE;
            endcase
        end
    end

    // Array writes; erase sweeps every word, the data array wraps harmlessly.
    always_ff @(posedge ref_clk) begin
        if (op_state_q == OP_ERASE) begin
            flash_mem[sweep_cnt_q] <= ERASED_WORD;
        end else if (op_state_q == OP_COMMIT && commit_ok_q) begin
            flash_mem[{commit_page_q, sweep_cnt_q[PAGE_AW-1:0]}] <=
                {page_hi[sweep_cnt_q[PAGE_AW-1:0]], page_lo[sweep_cnt_q[PAGE_AW-1:0]]};
        end
    end

    // Data array: byte write overwrites in place, no prior erase needed.
    always_ff @(posedge ref_clk) begin
        if (op_state_q == OP_ERASE) begin
            eeprom_mem[sweep_cnt_q[EEPROM_AW-1:0]] <= ERASED_BYTE;
        end else if (ee_write_go) begin
            eeprom_mem[ee_addr] <= ee_data;
        end
    end

    // Registered status outputs; the pending flag trails the state by a cycle.
    always_ff @(posedge ref_clk or negedge rst_sync_b_q) begin
        if (!rst_sync_b_q) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= op_busy;
        end
    end
    // Outputs come straight from their flops, so no glitch reaches a pin.
    assign serial_prog_data_out   = out_q;
    assign programming_enabled    = enabled_q;
    assign operation_pending_flag = pending_q;
    //////////////////////////////////////////////////////////////////////////
    // Checks on the framing, answers and sequencer.
    enable_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b_q)
        (op_state_q == OP_IDLE && !enabled_q) |=> (op_state_q == OP_IDLE))
        else $error("operation started without programming enable");
    echo_key_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b_q)
        (byte_done && bit_cnt_q[4:3] == BYTE_IDX_2 && insn_word[7:0] == ENABLE_KEY)
        |=> (out_sr_q == ENABLE_KEY))
        else $error("enable key not queued for echo");
    session_end_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b_q)
        !session_open |=> !enabled_q)
        else $error("session survived reset pin high");
    frame_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b_q)
        !session_open |=> (bit_cnt_q == '0))
        else $error("framing counter not cleared");
    sample_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b_q)
        (session_open && !sclk_rise) |=> (bit_cnt_q == $past(bit_cnt_q)))
        else $error("bit counted without a rising edge");
    shift_fall_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b_q)
        $changed(out_q) |-> ($past(sclk_fall) || !$past(session_open)))
        else $error("data out moved off a falling edge");
    erase_fill_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b_q)
        (op_state_q == OP_ERASE) |=> (flash_mem[$past(sweep_cnt_q)] == ERASED_WORD))
        else $error("erase left a word not all ones");
    ee_write_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b_q)
        ee_write_go |=> (eeprom_mem[$past(ee_addr)] == $past(ee_data)) ##1 op_busy)
        else $error("data byte not written or not timed");
    poll_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b_q)
        (byte_done && enabled_q && bit_cnt_q[4:3] == BYTE_IDX_3
         && insn_word[23:16] == OP_POLL) |=> (out_sr_q == {7'h00, $past(op_busy)}))
        else $error("poll answer does not show busy");
    ext_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_b_q)
        !ext_go |=> $stable(ext_addr_q))
        else $error("extended address changed without load");
endmodule // serial_isp_programming_port

// File: verification/isp_programmer_model.sv
`timescale 1ns/1ns
// Behavioural programmer on the far side of the serial link.
module isp_programmer_model #(
    parameter int POWER_UP_WAIT_CYCLES = 500000,
    parameter int HALF_CYCLES          = 4
) (
    input  wire logic ref_clk,
    input  wire logic serial_prog_data_out,
    output logic      serial_clk,
    output logic      serial_prog_data_in,
    output logic      prog_reset_b
);
    // Reset pin and serial clock stay low from power up.
    initial begin
        serial_clk          = 1'b0;
        serial_prog_data_in = 1'b0;
        prog_reset_b        = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // The default is 20 ms of core clock; benches shorten it.
    task automatic power_up();
        wait_cycles(POWER_UP_WAIT_CYCLES);
    endtask

    // Always a whole 32-bit frame, MSB first; each phase lasts four cycles,
    // longer than three, so no edge is lost. The answer bit is taken late
    // in the high phase, after the device has moved it on the fall.
    task automatic send_frame(input logic [31:0] cmd, output logic [31:0] resp);
        for (int i = 31; i >= 0; i--) begin
            serial_prog_data_in <= cmd[i];
            wait_cycles(HALF_CYCLES);
            serial_clk <= 1'b1;
            wait_cycles(HALF_CYCLES);
            resp[i] = serial_prog_data_out;
            serial_clk <= 1'b0;
        end
        // Released data line shows the inverse, never a stale value.
        serial_prog_data_in <= ~cmd[0];
        wait_cycles(HALF_CYCLES);
    endtask

    // Clock pulses with no whole frame behind them, as a programmer that has
    // lost step would send; only a reset pulse can realign the device.
    task automatic send_partial(input int n);
        repeat (n) begin
            wait_cycles(HALF_CYCLES);
            serial_clk <= 1'b1;
            wait_cycles(HALF_CYCLES);
            serial_clk <= 1'b0;
        end
        wait_cycles(HALF_CYCLES);
    endtask

    // Reset pulse of four cycles, above the two-cycle minimum.
    task automatic pulse_reset();
        prog_reset_b <= 1'b1;
        wait_cycles(4);
        prog_reset_b <= 1'b0;
        wait_cycles(8);
    endtask
endmodule // isp_programmer_model

// File: verification/test_serial_isp_programming_port.sv
`timescale 1ns/1ns
module test_serial_isp_programming_port import serial_isp_pkg::*;;
    logic        ref_clk;
    logic        rst_b;
    wire         prog_reset_b;
    wire         serial_clk;
    wire         serial_prog_data_in;
    wire         serial_prog_data_out;
    wire         programming_enabled;
    wire         operation_pending_flag;
    logic [31:0] last_resp;
    int          mismatches;
    int          n_tests;

    // Short waits keep the run small; erase still sweeps the whole array.
    serial_isp_programming_port #(
        .FLASH_WAIT_CYCLES (200),
        .DATA_WAIT_CYCLES  (300),
        .ERASE_WAIT_CYCLES (20000)
    ) serial_isp_programming_port_i (
        .ref_clk                (ref_clk),
        .rst_b                  (rst_b),
        .prog_reset_b           (prog_reset_b),
        .serial_clk             (serial_clk),
        .serial_prog_data_in    (serial_prog_data_in),
        .serial_prog_data_out   (serial_prog_data_out),
        .programming_enabled    (programming_enabled),
        .operation_pending_flag (operation_pending_flag)
    );

    isp_programmer_model #(
        .POWER_UP_WAIT_CYCLES (64)
    ) isp_programmer_model_i (
        .ref_clk              (ref_clk),
        .serial_prog_data_out (serial_prog_data_out),
        .serial_clk           (serial_clk),
        .serial_prog_data_in  (serial_prog_data_in),
        .prog_reset_b         (prog_reset_b)
    );

    // Core clock of 25 MHz.
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    //////////////////////////////////////////////////////////////////////
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    // One frame plus an idle gap so flags have settled before a check.
    task automatic run(input logic [31:0] cmd);
        isp_programmer_model_i.send_frame(cmd, last_resp);
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic read_check(input logic [31:0] cmd, input logic [7:0] exp);
        run(cmd);
        check_byte(last_resp[7:0], exp);
    endtask

    // Polling replaces the fixed wait; bounded so a stuck flag fails.
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            run({OP_POLL, 24'h000000});
            k++;
        end while (last_resp[0] !== 1'b0 && k < 200);
        check_bit(last_resp[0], 1'b0);
        check_bit(operation_pending_flag, 1'b0);
    endtask

    //////////////////////////////////////////////////////////////////////
    task automatic test_refused();
        run({OP_ENABLE, 24'h800000});
        check_bit(operation_pending_flag, 1'b0);
        check_bit(programming_enabled, 1'b0);
    endtask

    task automatic test_enable();
        run({OP_ENABLE, ENABLE_KEY, 16'h0000});
        check_byte(last_resp[15:8], ENABLE_KEY);
        check_bit(programming_enabled, 1'b1);
    endtask

    // The erase outlasts several polls, so the first poll must answer busy.
    task automatic test_erase();
        run({OP_ENABLE, 24'h800000});
        check_bit(operation_pending_flag, 1'b1);
        run({OP_POLL, 24'h000000});
        check_bit(last_resp[0], 1'b1);
        wait_idle();
        read_check({OP_READ_HI, 16'h3FFF, 8'h00}, ERASED_BYTE);
        read_check({OP_EE_READ, 16'h03FF, 8'h00}, ERASED_BYTE);
    endtask

    // Top data address, then an overwrite without any erase.
    task automatic test_data_write();
        run({OP_EE_WRITE, 16'h03FF, 8'hA5});
        check_bit(operation_pending_flag, 1'b1);
        wait_idle();
        read_check({OP_EE_READ, 16'h03FF, 8'h00}, 8'hA5);
        run({OP_EE_WRITE, 16'h03FF, 8'h3C});
        wait_idle();
        read_check({OP_EE_READ, 16'h03FF, 8'h00}, 8'h3C);
    endtask

    // Word 3 of page 1 is word 0x083; page 0 must stay erased.
    task automatic test_page_write();
        run({OP_LOAD_EXT, LOAD_EXT_KEY, 16'h0000});
        run({OP_PAGE_LO, 16'h0003, 8'h34});
        run({OP_PAGE_HI, 16'h0003, 8'h12});
        run({OP_WRITE_PAGE, 16'h0080, 8'h00});
        check_bit(operation_pending_flag, 1'b1);
        wait_idle();
        read_check({OP_READ_LO, 16'h0083, 8'h00}, 8'h34);
        read_check({OP_READ_HI, 16'h0083, 8'h00}, 8'h12);
        read_check({OP_READ_LO, 16'h0003, 8'h00}, ERASED_BYTE);
        run({OP_LOAD_EXT, LOAD_EXT_KEY, 16'h0100});
        read_check({OP_READ_LO, 16'h0083, 8'h00}, ERASED_BYTE);
        run({OP_LOAD_EXT, LOAD_EXT_KEY, 16'h0000});
        read_check({OP_READ_HI, 16'h0083, 8'h00}, 8'h12);
    endtask

    // A cut frame, then a reset pulse: reads only echo until enable is sent
    // again, and that echo lines up only if the framing restarted at zero.
    task automatic test_reset_resync();
        isp_programmer_model_i.send_partial(5);
        isp_programmer_model_i.pulse_reset();
        check_bit(programming_enabled, 1'b0);
        read_check({OP_EE_READ, 16'h03FF, 8'h00}, 8'hFF);
        test_enable();
        read_check({OP_EE_READ, 16'h03FF, 8'h00}, 8'h3C);
    endtask

    //////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence after a reset of 12 cycles.
    initial begin
        mismatches = 0;
        n_tests = 0;
        rst_b = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        isp_programmer_model_i.power_up();
        test_refused();
        test_enable();
        test_erase();
        test_data_write();
        test_page_write();
        test_reset_resync();
        print_verdict();
    end

    // The tests need about 28000 cycles; a hang stops well after that.
    initial begin
        repeat (80000) @(posedge ref_clk);
        mismatches++;
        print_verdict();
    end
endmodule // test_serial_isp_programming_port
